// *** tb/tb_vr_id_and_boot_config_regs.sv ***
// Self-checking bench for the identity and boot setup bank
`timescale 1ns/1ns
`default_nettype none
module tb_vr_id_and_boot_config_regs;
  localparam logic [7:0] MK = 8'h5a; // Value is arbitrary
  localparam logic [7:0] PT = 8'ha7; // Value is arbitrary
  localparam logic [7:0] RV = 8'h3c; // Value is arbitrary
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic conversion_on_in = 1'b0;
  logic [7:0] nvm_setup_in = 8'h61;
  vr_id_pkg::host_req_t host_req_in = '0;
  vr_id_pkg::host_rsp_t host_rsp_out, r;
  logic frame_valid_in, frame_bcast_hit_out, vbus_rd_in, vbus_rd_valid_out, step_10mv_out, ok, hit;
  logic [3:0] frame_addr_in;
  logic [1:0] bcast_sel_out, gp, bp;
  logic [7:0] vbus_rd_index_in, vbus_rd_data_out, boot_vid_out, d, cfg;
  logic [7:0] vid [16] = '{8'h00, 8'h65, 8'h6f, 8'h79, 8'h83, 8'h8d, 8'h97, 8'ha1, 8'hab, 8'haf, 8'hc9, 8'hdd,
    8'hfb, 8'h6f, 8'h79, 8'h83};
  logic [7:0] idc [3] = '{8'hc6, 8'hc8, 8'hc9};
  logic [7:0] idv [3] = '{MK, PT, RV};
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  always #20 clk_in = ~clk_in;
  vr_id_and_boot_config_regs #(.MAKER_CODE(MK), .PART_CODE(PT), .SILICON_REVISION(RV)) i_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .nvm_setup_in(nvm_setup_in), .conversion_on_in(conversion_on_in),
    .host_req_in(host_req_in), .host_rsp_out(host_rsp_out), .frame_valid_in(frame_valid_in),
    .frame_addr_in(frame_addr_in), .frame_bcast_hit_out(frame_bcast_hit_out), .vbus_rd_in(vbus_rd_in),
    .vbus_rd_index_in(vbus_rd_index_in), .vbus_rd_valid_out(vbus_rd_valid_out),
    .vbus_rd_data_out(vbus_rd_data_out), .step_10mv_out(step_10mv_out), .boot_vid_out(boot_vid_out),
    .bcast_sel_out(bcast_sel_out));
  vbus_master_model i_vbus (.clk_in(clk_in), .hit_in(frame_bcast_hit_out), .rd_valid_in(vbus_rd_valid_out),
    .rd_data_in(vbus_rd_data_out), .frame_valid_out(frame_valid_in), .frame_addr_out(frame_addr_in),
    .rd_out(vbus_rd_in), .rd_index_out(vbus_rd_index_in));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic host(input logic w, input logic [7:0] c, input logic [7:0] dat, input logic ack);
    @(posedge clk_in) #1;
    host_req_in = '{1'b1, w, c, dat};
    @(posedge clk_in) #1;
    host_req_in = '{1'b0, ~w, ~c, ~dat};
    r = host_rsp_out;
    check("response valid", 8'h01, {7'h00, r.valid});
    check("response ack", {7'h00, ack}, {7'h00, r.ack});
  endtask
  task automatic vread(input logic [7:0] idx, input logic [7:0] exp);
    i_vbus.read(idx, ok, d);
    check("vbus valid", 8'h01, {7'h00, ok});
    check("vbus data", exp, d);
  endtask
  task automatic fr(input logic [3:0] a, input logic exp);
    i_vbus.frame(a, hit);
    check("broadcast hit", {7'h00, exp}, {7'h00, hit});
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ********************
  // Test sequence
  // ********************
  initial begin
    repeat (2) @(posedge clk_in);
    #1 rstn_in = 1'b1;
    host(1'b0, 8'hc2, 8'h00, 1'b1);
    check("loaded setup", 8'h61, r.data);
    check("loaded boot vid", 8'hab, boot_vid_out);
    host(1'b0, 8'hc3, 8'h00, 1'b0);
    vread(8'h10, 8'h00);
    for (int i = 0; i < 3; i++) begin
      host(1'b1, idc[i], ~idv[i], 1'b0);
      host(1'b0, idc[i], 8'h00, 1'b1);
      check("identity byte", idv[i], r.data);
      vread(i[7:0], idv[i]);
    end
    for (int b = 0; b < 16; b++) begin
      gp = (b >= 1 && b <= 12) ? {~b[0], b[0]} : {b[0], b[0]};
      bp = (b >= 1 && b <= 12) ? {b[0], b[0]} : {~b[0], b[0]};
      cfg = {gp, b[3:0], 2'b01};
      host(1'b1, 8'hc2, cfg, 1'b1);
      if (b != 0)
        host(1'b1, 8'hc2, {bp, b[3:0], 2'b01}, 1'b0);
      host(1'b0, 8'hc2, 8'h00, 1'b1);
      check("setup readback", cfg, r.data);
      check("step size", {7'h00, gp[1] == gp[0]}, {7'h00, step_10mv_out});
      check("boot vid", vid[b], boot_vid_out);
      vread(8'h26, vid[b]);
    end
    for (int s = 0; s < 4; s++) begin
      host(1'b1, 8'hc2, {6'h00, s[1:0]}, 1'b1);
      vread(8'h0f, {6'h00, s[1:0]});
      fr(4'he, s[1]);
      fr(4'hf, s[0]);
      fr(4'h7, 1'b0);
    end
    conversion_on_in = 1'b1;
    host(1'b1, 8'hc2, 8'h40, 1'b1);
    fr(4'hf, 1'b1);
    check("held select", 8'h03, {6'h00, bcast_sel_out});
    check("held step", 8'h01, {7'h00, step_10mv_out});
    conversion_on_in = 1'b0;
    fr(4'hf, 1'b0);
    check("applied select", 8'h00, {6'h00, bcast_sel_out});
    check("applied step", 8'h00, {7'h00, step_10mv_out});
    rstn_in = 1'b0;
    @(posedge clk_in) #1 rstn_in = 1'b1;
    check("reset select", 8'h00, {6'h00, bcast_sel_out});
    host(1'b0, 8'hc2, 8'h00, 1'b1);
    check("reloaded setup", 8'h61, r.data);
    check("reloaded select", 8'h01, {6'h00, bcast_sel_out});
    close_out();
  end
  // Whole sequence needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      close_out();
    end
  end
endmodule
`default_nettype wire

// *** tb/vbus_master_model.sv ***
// Voltage-bus master model: frame addresses and register reads
`timescale 1ns/1ns
`default_nettype none
module vbus_master_model (
  input  wire logic       clk_in,
  input  wire logic       hit_in,
  input  wire logic       rd_valid_in,
  input  wire logic [7:0] rd_data_in,
  output var  logic       frame_valid_out,
  output var  logic [3:0] frame_addr_out,
  output var  logic       rd_out,
  output var  logic [7:0] rd_index_out
);
  initial begin
    frame_valid_out = 1'b0;
    frame_addr_out = 4'h0;
    rd_out = 1'b0;
    rd_index_out = 8'h00;
  end
  // Released lines show the inverse so a stale value never matches by luck
  task automatic frame(input logic [3:0] a, output logic hit);
    @(posedge clk_in) #1;
    frame_valid_out = 1'b1;
    frame_addr_out = a;
    @(posedge clk_in) #1;
    frame_valid_out = 1'b0;
    frame_addr_out = ~a;
    hit = hit_in;
  endtask
  task automatic read(input logic [7:0] idx, output logic ok, output logic [7:0] d);
    @(posedge clk_in) #1;
    rd_out = 1'b1;
    rd_index_out = idx;
    @(posedge clk_in) #1;
    rd_out = 1'b0;
    rd_index_out = ~idx;
    ok = rd_valid_in;
    d = rd_data_in;
  endtask
endmodule
`default_nettype wire

// *** tb/vr_id_regs_asserts.sv ***
// Port-level assertion checker for the identity and boot setup bank
`timescale 1ns/1ns
`default_nettype none
module vr_id_regs_checker #(
  parameter logic [7:0] MAKER_CODE       = 8'h5a,
  parameter logic [7:0] PART_CODE        = 8'ha7,
  parameter logic [7:0] SILICON_REVISION = 8'h3c
) (
  input wire logic                 clk_in,
  input wire logic                 rstn_in,
  input wire logic [7:0]           nvm_setup_in,
  input wire logic                 conversion_on_in,
  input wire vr_id_pkg::host_req_t host_req_in,
  input wire vr_id_pkg::host_rsp_t host_rsp_out,
  input wire logic                 frame_valid_in,
  input wire logic [3:0]           frame_addr_in,
  input wire logic                 frame_bcast_hit_out,
  input wire logic                 vbus_rd_in,
  input wire logic [7:0]           vbus_rd_index_in,
  input wire logic                 vbus_rd_valid_out,
  input wire logic [7:0]           vbus_rd_data_out,
  input wire logic                 step_10mv_out,
  input wire logic [7:0]           boot_vid_out,
  input wire logic [1:0]           bcast_sel_out
);
  // Init edge after reset takes no requests
  logic up;
  wire logic       hv = host_req_in.valid && up;
  wire logic       hw = host_req_in.write;
  wire logic [7:0] hc = host_req_in.code;
  wire logic [7:0] hd = host_req_in.data;
  wire logic       fine = hd[5:2] inside {[4'h1:4'hc]};
  wire logic       coarse = hd[7:6] == 2'h0 || hd[7:6] == 2'h3;
  wire logic       good = hd[5:2] == 4'h0 || fine != coarse;
  wire logic       rd = up && vbus_rd_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
      up <= 1'b0;
    else
      up <= 1'b1;
  property p_id_refuse;
    hv && hw && hc inside {8'hc6, 8'hc8, 8'hc9} |=> host_rsp_out.valid && !host_rsp_out.ack;
  endproperty
  a_id_refuse: assert property (p_id_refuse) else $error("identity write not refused");
  property p_maker;
    hv && !hw && hc == 8'hc6 |=> host_rsp_out.ack && host_rsp_out.data == MAKER_CODE;
  endproperty
  a_maker: assert property (p_maker) else $error("maker byte read wrong");
  property p_pair;
    hv && hw && hc == 8'hc2 |=> host_rsp_out.valid && host_rsp_out.ack == $past(good);
  endproperty
  a_pair: assert property (p_pair) else $error("setup pairing answer wrong");
  property p_step;
    hv && hw && hc == 8'hc2 && good && !conversion_on_in |=> ##1 step_10mv_out == $past(coarse, 2);
  endproperty
  a_step: assert property (p_step) else $error("step size not applied");
  property p_hold;
    up && conversion_on_in |-> ##2 $stable(bcast_sel_out) && $stable(step_10mv_out);
  endproperty
  a_hold: assert property (p_hold) else $error("setting changed while converting");
  property p_hit;
    up && frame_valid_in |=> frame_bcast_hit_out == (($past(frame_addr_in) == 4'hf && bcast_sel_out[0])
      || ($past(frame_addr_in) == 4'he && bcast_sel_out[1]));
  endproperty
  a_hit: assert property (p_hit) else $error("broadcast hit wrong");
  property p_ids;
    rd && vbus_rd_index_in < 8'h03 |=> vbus_rd_valid_out && vbus_rd_data_out ==
      ($past(vbus_rd_index_in) == 8'h00 ? MAKER_CODE : $past(vbus_rd_index_in) == 8'h01 ? PART_CODE : SILICON_REVISION);
  endproperty
  a_ids: assert property (p_ids) else $error("identity mirror wrong");
  property p_bmirror;
    rd && vbus_rd_index_in == 8'h0f |=> vbus_rd_data_out == {6'h00, $past(bcast_sel_out)};
  endproperty
  a_bmirror: assert property (p_bmirror) else $error("broadcast mirror wrong");
  property p_boot;
    rd && vbus_rd_index_in == 8'h26 |=> vbus_rd_valid_out && vbus_rd_data_out == $past(boot_vid_out);
  endproperty
  a_boot: assert property (p_boot) else $error("boot vid mirror wrong");
endmodule
bind vr_id_and_boot_config_regs vr_id_regs_checker #(.MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE),
  .SILICON_REVISION(SILICON_REVISION)) i_chk (.clk_in(clk_in), .rstn_in(rstn_in), .nvm_setup_in(nvm_setup_in),
  .conversion_on_in(conversion_on_in), .host_req_in(host_req_in), .host_rsp_out(host_rsp_out),
  .frame_valid_in(frame_valid_in), .frame_addr_in(frame_addr_in), .frame_bcast_hit_out(frame_bcast_hit_out),
  .vbus_rd_in(vbus_rd_in), .vbus_rd_index_in(vbus_rd_index_in), .vbus_rd_valid_out(vbus_rd_valid_out),
  .vbus_rd_data_out(vbus_rd_data_out), .step_10mv_out(step_10mv_out), .boot_vid_out(boot_vid_out),
  .bcast_sel_out(bcast_sel_out));
`default_nettype wire

// *** verilog/vr_id_and_boot_config_regs.sv ***
// Identity bytes, boot voltage and broadcast setup with voltage-bus mirrors
`timescale 1ns/1ns
`default_nettype none
`include "vr_id_cfg.svh"

// Operation
// R1 - Select 00b: ignore broadcast frames 0Eh, 0Fh
// R2 - 01b answers 0Fh, 10b 0Eh, 11b both
// R3 - Mirror broadcast select at bus index 0Fh
// R4 - New broadcast select waits for conversion off
// R5 - Boot codes 0-12 map, 1-12 need fine step
// R6 - Boot codes 13-15 map, need coarse step
// R7 - Maker byte read-only at C6h
// R8 - Maker byte loaded to bus index 00h
// R9 - Part byte read-only at C8h
// R10 - Part byte loaded to bus index 01h
// R11 - Revision byte read-only at C9h
// R12 - Revision byte loaded to bus index 02h
// R13 - Refuse setup writes with bad boot pairing
// R14 - Step 5 mV for 01b/10b, else 10
// R15 - Boot VID code mirrored at index 26h
// R16 - Identity writes refused, state unchanged
module vr_id_and_boot_config_regs #(
  parameter logic [7:0] MAKER_CODE       = 8'h5a, // Value is arbitrary
  parameter logic [7:0] PART_CODE        = 8'ha7, // Value is arbitrary
  parameter logic [7:0] SILICON_REVISION = 8'h3c  // Value is arbitrary
) (
  input  wire logic                 clk_in,
  input  wire logic                 rstn_in,
  input  wire logic [7:0]           nvm_setup_in,
  input  wire logic                 conversion_on_in,
  input  wire vr_id_pkg::host_req_t host_req_in,
  output var  vr_id_pkg::host_rsp_t host_rsp_out,
  input  wire logic                 frame_valid_in,
  input  wire logic [3:0]           frame_addr_in,
  output logic                      frame_bcast_hit_out,
  input  wire logic                 vbus_rd_in,
  input  wire logic [7:0]           vbus_rd_index_in,
  output logic                      vbus_rd_valid_out,
  output logic [7:0]                vbus_rd_data_out,
  output logic                      step_10mv_out,
  output logic [7:0]                boot_vid_out,
  output logic [1:0]                bcast_sel_out
);

  // ***************************************************
  // Decode functions
  // ***************************************************
  function automatic logic [7:0] boot_to_vid(input logic [3:0] boot);
    logic [7:0] vid;
    vid = 8'h00;
    case (boot)
      4'h0:    vid = 8'h00;
      4'h1:    vid = 8'h65;
      4'h2:    vid = 8'h6f;
      4'h3:    vid = 8'h79;
      4'h4:    vid = 8'h83;
      4'h5:    vid = 8'h8d;
      4'h6:    vid = 8'h97;
      4'h7:    vid = 8'ha1;
      4'h8:    vid = 8'hab;
      4'h9:    vid = 8'haf;
      4'ha:    vid = 8'hc9;
      4'hb:    vid = 8'hdd;
      4'hc:    vid = 8'hfb;
      4'hd:    vid = 8'h6f;
      4'he:    vid = 8'h79;
      4'hf:    vid = 8'h83;
      default: vid = 8'h00;
    endcase
    return vid;
  endfunction

  // Shared by the pairing check and the step output, which follows the applied proto
  function automatic logic is_fine_step(input logic [1:0] proto);
    return (proto == 2'b01) || (proto == 2'b10);
  endfunction

  // Boot code zero names no voltage and pairs with either step
  function automatic logic pairing_ok(input logic [7:0] byte_val);
    logic [1:0] proto;
    logic [3:0] boot;
    proto = byte_val[`CFG_PROTO_MSB:`CFG_PROTO_LSB];
    boot  = byte_val[`CFG_BOOT_MSB:`CFG_BOOT_LSB];
    if (boot == 4'h0) begin
      return 1'b1;
    end
    if (boot <= `BOOT_FINE_LAST) begin
      return is_fine_step(proto);
    end
    return !is_fine_step(proto);
  endfunction

  // ***************************************************
  // State
  // ***************************************************
  logic                init_done;
  vr_id_pkg::setup_t   setup;
  logic [1:0]          eff_proto;
  logic [1:0]          eff_bcast;
  logic [7:0]          maker_mirror;
  logic [7:0]          part_mirror;
  logic [7:0]          revision_mirror;
  logic [7:0]          broadcast_active_mirror;
  logic [7:0]          boot_vid_mirror;

  // ***************************************************
  // Host command decode
  // ***************************************************
  wire logic       hit_setup;
  wire logic       hit_maker;
  wire logic       hit_part;
  wire logic       hit_rev;
  wire logic       hit_ident;
  wire logic       wr_req;
  wire logic       rd_req;
  wire logic       setup_wr_ok;
  wire logic       rd_ack;
  wire logic       wr_ack;
  wire logic       hit_known;
  wire logic       host_taken;
  wire logic       host_ack;
  wire logic [7:0] setup_byte;
  wire logic [7:0] rd_data;

  assign setup_byte  = {setup.proto, setup.boot, setup.bcast};
  assign hit_setup   = host_req_in.code == `CMD_BUS_SETUP_CONFIG;
  assign hit_maker   = host_req_in.code == `CMD_MAKER_CODE;
  assign hit_part    = host_req_in.code == `CMD_PART_CODE;
  assign hit_rev     = host_req_in.code == `CMD_SILICON_REVISION;
  assign hit_ident   = hit_maker || hit_part || hit_rev;
  assign wr_req      = init_done && host_req_in.valid && host_req_in.write;
  assign rd_req      = init_done && host_req_in.valid && !host_req_in.write;
  assign setup_wr_ok = wr_req && hit_setup && pairing_ok(host_req_in.data); // R13
  // Only the setup byte takes writes; identity codes fall to a refusal
  assign wr_ack      = setup_wr_ok; // R16
  assign hit_known   = hit_setup || hit_ident;
  assign rd_ack      = rd_req && hit_known;
  assign host_taken  = wr_req || rd_req;
  assign host_ack    = wr_ack || rd_ack; // R16

  assign rd_data = !rd_req   ? `RST_BYTE :
                   hit_setup ? setup_byte :
                   hit_maker ? MAKER_CODE : // R7
                   hit_part  ? PART_CODE : // R9
                   hit_rev   ? SILICON_REVISION : // R11
                               `RST_BYTE;

  // ***************************************************
  // Broadcast frame decode
  // ***************************************************
  wire logic addr_high;
  wire logic addr_low;
  wire logic take_high;
  wire logic take_low;
  wire logic bcast_hit;

  // Effective select only; a stored but unapplied value has no say
  assign addr_high = frame_addr_in == `BCAST_ADDR_HIGH;
  assign addr_low  = frame_addr_in == `BCAST_ADDR_LOW;
  assign take_high = eff_bcast == vr_id_pkg::BCAST_HIGH_ONLY || eff_bcast == vr_id_pkg::BCAST_BOTH; // R2
  assign take_low  = eff_bcast == vr_id_pkg::BCAST_LOW_ONLY || eff_bcast == vr_id_pkg::BCAST_BOTH; // R2
  assign bcast_hit = frame_valid_in && ((addr_high && take_high) || (addr_low && take_low)); // R1 R2

  // ***************************************************
  // Voltage-bus register read decode
  // ***************************************************
  wire logic       idx_maker;
  wire logic       idx_part;
  wire logic       idx_rev;
  wire logic       idx_bcast;
  wire logic       idx_boot;
  wire logic [7:0] vbus_data;

  assign idx_maker = vbus_rd_index_in == `VBUS_IDX_MAKER;
  assign idx_part  = vbus_rd_index_in == `VBUS_IDX_PART;
  assign idx_rev   = vbus_rd_index_in == `VBUS_IDX_REVISION;
  assign idx_bcast = vbus_rd_index_in == `VBUS_IDX_BROADCAST;
  assign idx_boot  = vbus_rd_index_in == `VBUS_IDX_BOOT_VID;
  // Unmapped indices read zero so a stray read is harmless
  assign vbus_data = !vbus_rd_in ? `RST_BYTE :
                     idx_maker   ? maker_mirror :
                     idx_part    ? part_mirror :
                     idx_rev     ? revision_mirror :
                     idx_bcast   ? broadcast_active_mirror :
                     idx_boot    ? boot_vid_mirror :
                                   `RST_BYTE;

  // ***************************************************
  // Next values
  // ***************************************************
  wire vr_id_pkg::setup_t next_setup;
  wire logic [7:0]        next_boot_vid;
  wire logic              apply_now;

  // Stored byte reads back at once; proto and broadcast act later
  assign next_setup = !init_done  ? vr_id_pkg::setup_t'(nvm_setup_in) :
                      setup_wr_ok ? vr_id_pkg::setup_t'(host_req_in.data) :
                                    setup;
  // Boot code is live; the other fields only with the stage idle
  assign next_boot_vid = boot_to_vid(setup.boot); // R5 R6
  assign apply_now     = !init_done || !conversion_on_in; // R4

  // ***************************************************
  // Power-on load
  // ***************************************************
  // Constants are fixed in hardware but loaded after release so
  // the mirrors read zero until the first clock, as on a cold start
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      init_done       <= 1'b0;
      maker_mirror    <= `RST_BYTE;
      part_mirror     <= `RST_BYTE;
      revision_mirror <= `RST_BYTE;
    end else if (!init_done) begin
      init_done       <= 1'b1;
      maker_mirror    <= MAKER_CODE; // R8
      part_mirror     <= PART_CODE; // R10
      revision_mirror <= SILICON_REVISION; // R12
    end
  end

  // ***************************************************
  // Setup byte and effective fields
  // ***************************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      setup <= vr_id_pkg::setup_t'(`RST_CONFIG);
    end else begin
      setup <= next_setup; // R13
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      eff_proto <= 2'b00;
      eff_bcast <= 2'b00;
    end else if (apply_now) begin
      eff_proto <= next_setup.proto; // R4
      eff_bcast <= next_setup.bcast; // R4
    end
  end

  // ***************************************************
  // Voltage-bus mirrors
  // ***************************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      broadcast_active_mirror <= `RST_BYTE;
      boot_vid_mirror         <= `RST_BYTE;
    end else begin
      broadcast_active_mirror <= {6'h00, eff_bcast}; // R3
      boot_vid_mirror         <= next_boot_vid; // R15
    end
  end

  // ***************************************************
  // Host answers
  // ***************************************************
  // Every request after the init edge gets one answer a cycle later; a refused
  // write leaves all state as it was
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      host_rsp_out <= '0;
    end else begin
      host_rsp_out.valid <= host_taken;
      host_rsp_out.ack   <= host_ack; // R16
      host_rsp_out.data  <= rd_data;
    end
  end

  // ***************************************************
  // Frame and register outputs
  // ***************************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      frame_bcast_hit_out <= 1'b0;
      vbus_rd_valid_out   <= 1'b0;
      vbus_rd_data_out    <= `RST_BYTE;
    end else begin
      frame_bcast_hit_out <= bcast_hit; // R1
      vbus_rd_valid_out   <= vbus_rd_in;
      vbus_rd_data_out    <= vbus_data;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      step_10mv_out <= 1'b1;
      boot_vid_out  <= `RST_BYTE;
      bcast_sel_out <= 2'b00;
    end else begin
      step_10mv_out <= !is_fine_step(eff_proto); // R14
      boot_vid_out  <= next_boot_vid;
      bcast_sel_out <= eff_bcast;
    end
  end

endmodule
`default_nettype wire

// *** verilog/vr_id_cfg.svh ***
// Offsets, field positions, reset values and codes for the identity and boot setup bank
`ifndef VR_ID_CFG_SVH
`define VR_ID_CFG_SVH

// ***************************************************
// Command codes on the serial host port
// ***************************************************
`define CMD_BUS_SETUP_CONFIG   8'hc2
`define CMD_MAKER_CODE         8'hc6
`define CMD_PART_CODE          8'hc8
`define CMD_SILICON_REVISION   8'hc9

// ***************************************************
// Voltage-identification bus register indices
// ***************************************************
`define VBUS_IDX_MAKER         8'h00
`define VBUS_IDX_PART          8'h01
`define VBUS_IDX_REVISION      8'h02
`define VBUS_IDX_BROADCAST     8'h0f
`define VBUS_IDX_BOOT_VID      8'h26

// ***************************************************
// Broadcast frame addresses
// ***************************************************
`define BCAST_ADDR_LOW         4'he
`define BCAST_ADDR_HIGH        4'hf

// ***************************************************
// Setup byte field positions
// ***************************************************
`define CFG_PROTO_MSB          7
`define CFG_PROTO_LSB          6
`define CFG_BOOT_MSB           5
`define CFG_BOOT_LSB           2
`define CFG_BCAST_MSB          1
`define CFG_BCAST_LSB          0

// ***************************************************
// Reset values
// ***************************************************
`define RST_CONFIG             8'h00
`define RST_BYTE               8'h00

// Last boot code of the fine step group
`define BOOT_FINE_LAST         4'hc

`endif

// *** verilog/vr_id_pkg.sv ***
// Types shared by the identity and boot setup bank
`default_nettype none
package vr_id_pkg;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] code;
    logic [7:0] data;
  } host_req_t;

  typedef struct packed {
    logic       valid;
    logic       ack;
    logic [7:0] data;
  } host_rsp_t;

  typedef struct packed {
    logic [1:0] proto;
    logic [3:0] boot;
    logic [1:0] bcast;
  } setup_t;

  typedef enum logic [1:0] {
    BCAST_NONE,
    BCAST_HIGH_ONLY,
    BCAST_LOW_ONLY,
    BCAST_BOTH
  } bcast_sel_t;

endpackage
`default_nettype wire
